// File: verilog/sfp_regs.svh
// Purpose: Opcodes and timing counts of the serial flash command logic
// Assumes: 125 MHz core clock
// Notes:   Definitions only
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SFP_OP_ID_LONG   8'h9F
`define SFP_OP_ID_SHORT  8'hAB
`define SFP_OP_WR_EN     8'h06
`define SFP_OP_WR_DIS    8'h04
`define SFP_OP_PWR_DOWN  8'hB9
`define SFP_OP_CHIP_ER_A 8'h60
`define SFP_OP_CHIP_ER_B 8'hC7
`define SFP_OP_SSEC_ER_A 8'h20
`define SFP_OP_SSEC_ER_B 8'hD7
`define SFP_OP_SEC_ER    8'hD8
`define SFP_OP_PAGE_PROG 8'h02
`define SFP_OP_STAT_WR   8'h01

// ----------------------------------------------------------------------
// Frame lengths in bytes
// ----------------------------------------------------------------------
`define SFP_LEN_SINGLE   4'h1
`define SFP_LEN_STAT_WR  4'h2
`define SFP_LEN_ERASE    4'h4
`define SFP_LEN_PROG_MIN 4'h5
`define SFP_ID_DUMMY_END 4'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SFP_CLK_NS       8
`define SFP_PU_WAIT_US   500
`define SFP_PU_WAIT_CYC  ((`SFP_PU_WAIT_US * 1000 + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_OP_CYCLES    1000
`define SFP_SCK_HALF     8
`define SFP_SCK_HALF_MIN 8

`endif

// File: verilog/sfp_pkg.sv
// Purpose: Types shared by both ends of the serial flash link
// Assumes: Constants live in sfp_regs.svh
// Notes:   State codes are written out
package sfp_pkg;

    // ------------------------------------------------------------------
    // Device frame modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        M_CMD      = 3'h0,
        M_ID_LONG  = 3'h1,
        M_ID_DUMMY = 3'h2,
        M_ID_SHORT = 3'h3,
        M_WDATA    = 3'h4,
        M_IGNORE   = 3'h5
    } sfp_mode_e;

    // ------------------------------------------------------------------
    // Host states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        H_PU    = 2'h0,
        H_IDLE  = 2'h1,
        H_SHIFT = 2'h2,
        H_END   = 2'h3
    } sfp_hstate_e;

endpackage : sfp_pkg

// File: verilog/sfp_if.sv
// Purpose: Four-wire serial link plus hold pin between host and device
// Assumes: Data output is pulled high when nobody drives it
// Notes:   so_line is the resolved wire level
interface sfp_if;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic so;
    logic so_oe;
    logic so_line;

    // Pull-up when the output is released
    assign so_line = so_oe ? so : 1'b1;

    modport dev  (input sck, cs_n, si, hold_n, output so, so_oe);
    modport host (output sck, cs_n, si, hold_n, input so_line);
endinterface : sfp_if

// File: verilog/sfp_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   Stage one feeds stage two only
module sfp_sync #(
    parameter int unsigned W   = 1,
    parameter logic        RST = 1'b0
) (
    // Clock and control
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_ce,
    // Data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    initial if (W < 1) $error("sfp_sync: W must be at least 1");

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            meta_q <= {W{RST}};
            o_q    <= {W{RST}};
        end
        else if (i_ce)
        begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : sfp_sync

// File: verilog/sfp_dev.sv
// Purpose: Device end: command decode, identification reads, hold,
//          power-down and write protection of a serial flash
// Assumes: Link pins sampled by i_clk, several cycles per serial bit
// Notes:   Mode 0 or 3; data in on sck rise, data out on sck fall
//
// Function
// - Ignore identification reads while operation busy
// - Long ID: opcode, maker, type, capacity, reserved
// - Long ID repeats its four bytes
// - Short ID: opcode, 24 dummy bits, one byte
// - Short ID byte repeats while clocked
// - ID data driven on falling edges; cs ends
// - Hold on fall with sck low, leave on rise
// - Host keeps hold stable while sck high
// - Hold only with cs low; cs rise clears
// - Held: output released, sck and data ignored
// - Host waits power-up time before commands
// - Start in standby, power-down only by command
// - Reset brings all state to defined values
// - Write commands need cs rise on byte boundary
// - Page program needs whole data bytes
// - Status write with extra cycles is ignored
// - Write enable clears when operation completes
// - Short ID opcode byte leaves power-down
`include "sfp_regs.svh"
module sfp_dev #(
    parameter int unsigned OP_CYCLES = `SFP_OP_CYCLES,
    parameter logic [7:0]  MAKER_ID  = 8'hA7, // Arbitrary value
    parameter logic [7:0]  MEM_TYPE  = 8'h5B, // Arbitrary value
    parameter logic [7:0]  MEM_SIZE  = 8'h2C, // Arbitrary value
    parameter logic [7:0]  RSVD_ID   = 8'hE1, // Arbitrary value
    parameter logic [7:0]  SHORT_ID  = 8'h4D  // Arbitrary value
) (
    // Clock and control
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_ce,
    // Serial link
    sfp_if.dev              bus,
    // Core status
    output logic            o_busy,
    output logic            o_wel,
    output logic            o_pwr_down,
    output logic            o_hold,
    output logic            o_op_start,
    output logic [7:0]      o_op_code,
    output logic [7:0]      o_status
);
    initial if (OP_CYCLES < 1 || OP_CYCLES > 32'hFFFF)
        $error("sfp_dev: OP_CYCLES out of range");

    // ------------------------------------------------------------------
    // Pin sampling and edges
    // ------------------------------------------------------------------
    logic [3:0]        pins_s;
    logic              s_sck;
    logic              s_cs_n;
    logic              s_si;
    logic              s_hold_n;
    logic              sck_d_q;
    logic              cs_d_q;
    logic              hold_d_q;
    logic              hold_q;
    logic              act;
    logic              rise;
    logic              fall;
    logic              cs_rise;

    sfp_sync #(.W(4), .RST(1'b1)) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_d       ({bus.sck, bus.cs_n, bus.si, bus.hold_n}),
        .o_q       (pins_s)
    );

    assign s_sck    = pins_s[3];
    assign s_cs_n   = pins_s[2];
    assign s_si     = pins_s[1];
    assign s_hold_n = pins_s[0];

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sck_d_q  <= 1'b1;
            cs_d_q   <= 1'b1;
            hold_d_q <= 1'b1;
        end
        else if (i_ce)
        begin
            sck_d_q  <= s_sck;
            cs_d_q   <= s_cs_n;
            hold_d_q <= s_hold_n;
        end
    end

    // ------------------------------------------------------------------
    // Hold state
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            hold_q <= 1'b0;
        else if (i_ce)
        begin
            if (s_cs_n)
                hold_q <= 1'b0;
            else if (!hold_q && hold_d_q && !s_hold_n && !s_sck)
                hold_q <= 1'b1;
            else if (hold_q && s_hold_n && !hold_d_q)
                hold_q <= 1'b0;
        end
    end

    assign act     = ~s_cs_n & ~hold_q;
    assign rise    = act & s_sck & ~sck_d_q;
    assign fall    = act & ~s_sck & sck_d_q;
    assign cs_rise = s_cs_n & ~cs_d_q;

    // ------------------------------------------------------------------
    // Input shifter and counters
    // ------------------------------------------------------------------
    logic [6:0]        in_sh_q;
    logic [2:0]        bit_cnt_q;
    logic [3:0]        byte_cnt_q;
    logic              byte_done;
    logic [7:0]        new_byte;

    assign byte_done = rise & (bit_cnt_q == 3'h7);
    assign new_byte  = {in_sh_q, s_si};

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || (i_ce && s_cs_n))
        begin
            in_sh_q    <= 7'h00;
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 4'h0;
        end
        else if (i_ce && rise)
        begin
            in_sh_q   <= new_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_done && byte_cnt_q != 4'hF)
                byte_cnt_q <= byte_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------
    sfp_pkg::sfp_mode_e mode_q;
    logic [7:0]        cmd_q;
    logic [7:0]        data_q;
    logic              pd_q;
    logic              busy;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || (i_ce && s_cs_n))
            mode_q <= sfp_pkg::M_CMD;
        else if (i_ce && byte_done)
        begin
            case (mode_q)
                sfp_pkg::M_CMD:
                begin
                    if (new_byte == `SFP_OP_ID_LONG)
                        mode_q <= (busy || pd_q) ? sfp_pkg::M_IGNORE
                                                 : sfp_pkg::M_ID_LONG;
                    else if (new_byte == `SFP_OP_ID_SHORT)
                        mode_q <= busy ? sfp_pkg::M_IGNORE
                                       : sfp_pkg::M_ID_DUMMY;
                    else if (pd_q)
                        mode_q <= sfp_pkg::M_IGNORE;
                    else
                        mode_q <= sfp_pkg::M_WDATA;
                end
                sfp_pkg::M_ID_DUMMY:
                    if (byte_cnt_q == `SFP_ID_DUMMY_END)
                        mode_q <= sfp_pkg::M_ID_SHORT;
                sfp_pkg::M_ID_LONG,
                sfp_pkg::M_ID_SHORT,
                sfp_pkg::M_WDATA,
                sfp_pkg::M_IGNORE:
                    mode_q <= mode_q;
                default:
                    mode_q <= sfp_pkg::M_IGNORE;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            cmd_q  <= 8'h00;
            data_q <= 8'h00;
        end
        else if (i_ce && byte_done)
        begin
            if (mode_q == sfp_pkg::M_CMD)
                cmd_q <= new_byte;
            if (mode_q == sfp_pkg::M_WDATA && byte_cnt_q == 4'h1)
                data_q <= new_byte;
        end
    end

    // ------------------------------------------------------------------
    // Command execution at chip select rise
    // ------------------------------------------------------------------
    logic              exec_ok;
    logic              wr_ok;
    logic              start_op;
    logic              is_single;
    logic [15:0]       op_cnt_q;
    logic              op_done;
    logic              wel_q;

    assign is_single = byte_cnt_q == `SFP_LEN_SINGLE;
    assign exec_ok   = cs_rise & (bit_cnt_q == 3'h0) & ~pd_q & ~busy
                     & (mode_q == sfp_pkg::M_WDATA);
    assign wr_ok     = exec_ok & wel_q;
    assign start_op  = wr_ok & (
        ((cmd_q == `SFP_OP_CHIP_ER_A || cmd_q == `SFP_OP_CHIP_ER_B) && is_single)
        || ((cmd_q == `SFP_OP_SSEC_ER_A || cmd_q == `SFP_OP_SSEC_ER_B
             || cmd_q == `SFP_OP_SEC_ER) && byte_cnt_q == `SFP_LEN_ERASE)
        || (cmd_q == `SFP_OP_PAGE_PROG && byte_cnt_q >= `SFP_LEN_PROG_MIN)
        || (cmd_q == `SFP_OP_STAT_WR && byte_cnt_q == `SFP_LEN_STAT_WR));

    assign busy    = op_cnt_q != 16'h0000;
    assign op_done = op_cnt_q == 16'h0001;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            op_cnt_q <= 16'h0000;
        else if (i_ce)
        begin
            if (start_op)
                op_cnt_q <= OP_CYCLES[15:0];
            else if (busy)
                op_cnt_q <= op_cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            wel_q <= 1'b0;
        else if (i_ce)
        begin
            if (exec_ok && cmd_q == `SFP_OP_WR_EN && is_single)
                wel_q <= 1'b1;
            else if (op_done)
                wel_q <= 1'b0;
            else if (exec_ok && cmd_q == `SFP_OP_WR_DIS && is_single)
                wel_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            pd_q <= 1'b0;
        else if (i_ce)
        begin
            if (byte_done && mode_q == sfp_pkg::M_CMD && new_byte == `SFP_OP_ID_SHORT)
                pd_q <= 1'b0;
            else if (exec_ok && cmd_q == `SFP_OP_PWR_DOWN && is_single)
                pd_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_op_start <= 1'b0;
            o_op_code  <= 8'h00;
            o_status   <= 8'h00;
        end
        else if (i_ce)
        begin
            o_op_start <= start_op;
            if (start_op)
                o_op_code <= cmd_q;
            if (start_op && cmd_q == `SFP_OP_STAT_WR)
                o_status <= data_q;
        end
    end

    // ------------------------------------------------------------------
    // Identification output
    // ------------------------------------------------------------------
    logic [7:0]        id_tab [4];
    logic [1:0]        id_idx_q;
    logic [7:0]        cur_byte;
    logic              so_q;
    logic              oe_q;

    assign id_tab[0] = MAKER_ID;
    assign id_tab[1] = MEM_TYPE;
    assign id_tab[2] = MEM_SIZE;
    assign id_tab[3] = RSVD_ID;
    assign cur_byte  = (mode_q == sfp_pkg::M_ID_LONG) ? id_tab[id_idx_q]
                                                      : SHORT_ID;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || (i_ce && s_cs_n))
            id_idx_q <= 2'h0;
        else if (i_ce && byte_done && mode_q == sfp_pkg::M_ID_LONG)
            id_idx_q <= id_idx_q + 2'h1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || (i_ce && s_cs_n))
        begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else if (i_ce && fall && (mode_q == sfp_pkg::M_ID_LONG
                                  || mode_q == sfp_pkg::M_ID_SHORT))
        begin
            so_q <= cur_byte[3'h7 - bit_cnt_q];
            oe_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bus.so      = so_q;
    assign bus.so_oe   = oe_q & act;
    assign o_busy      = busy;
    assign o_wel       = wel_q;
    assign o_pwr_down  = pd_q;
    assign o_hold      = hold_q;
endmodule : sfp_dev

// File: verilog/sfp_host.sv
// Purpose: Host end: waits out power-up, then runs framed transfers
// Assumes: Mode 0; sck made here by dividing i_clk
// Notes:   Up to 40 bits sent, then up to 15 bytes read
`include "sfp_regs.svh"
module sfp_host #(
    parameter int unsigned HALF      = `SFP_SCK_HALF,
    parameter int unsigned PU_CYCLES = `SFP_PU_WAIT_CYC
) (
    // Clock and control
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    // Serial link
    sfp_if.host              bus,
    // Request
    input  wire logic        i_start,
    input  wire logic [39:0] i_tx_data,
    input  wire logic [5:0]  i_tx_bits,
    input  wire logic [3:0]  i_rx_bytes,
    input  wire logic        i_hold,
    // Answer
    output logic             o_ready,
    output logic [7:0]       o_rx_data,
    output logic             o_rx_valid
);
    initial if (HALF < `SFP_SCK_HALF_MIN || HALF > 255 || PU_CYCLES < 1
                || PU_CYCLES > 32'h1FFFF)
        $error("sfp_host: parameter out of range");

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sfp_pkg::sfp_hstate_e st_q;
    logic [16:0]       pu_q;
    logic [7:0]        div_q;
    logic              tick;
    logic              sck_q;
    logic              cs_n_q;
    logic              si_q;
    logic              hold_n_q;
    logic [39:0]       tx_q;
    logic [7:0]        left_q;
    logic [5:0]        txl_q;
    logic [7:0]        rx_q;
    logic [2:0]        rxb_q;
    logic              s_so;

    sfp_sync #(.W(1), .RST(1'b1)) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_d       (bus.so_line),
        .o_q       (s_so)
    );

    // No clock edge may be made while held, so sck freezes with hold_n
    assign tick = hold_n_q & (div_q == 8'(HALF - 1));

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || (i_ce && (st_q == sfp_pkg::H_IDLE || tick)))
            div_q <= 8'h00;
        else if (i_ce && hold_n_q)
            div_q <= div_q + 8'h01;
    end

    // ------------------------------------------------------------------
    // Hold pin, changed only while sck is low
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            hold_n_q <= 1'b1;
        else if (i_ce && !sck_q && !tick)
            hold_n_q <= ~i_hold;
    end

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_q       <= sfp_pkg::H_PU;
            pu_q       <= 17'(PU_CYCLES);
            sck_q      <= 1'b0;
            cs_n_q     <= 1'b1;
            si_q       <= 1'b0;
            tx_q       <= 40'h0;
            left_q     <= 8'h00;
            txl_q      <= 6'h00;
            rx_q       <= 8'h00;
            rxb_q      <= 3'h0;
            o_rx_data  <= 8'h00;
            o_rx_valid <= 1'b0;
        end
        else if (i_ce)
        begin
            o_rx_valid <= 1'b0;
            case (st_q)
                sfp_pkg::H_PU:
                begin
                    pu_q <= pu_q - 17'h00001;
                    if (pu_q == 17'h00001)
                        st_q <= sfp_pkg::H_IDLE;
                end
                sfp_pkg::H_IDLE:
                    if (i_start)
                    begin
                        cs_n_q <= 1'b0;
                        si_q   <= i_tx_data[39];
                        tx_q   <= {i_tx_data[38:0], 1'b0};
                        txl_q  <= i_tx_bits;
                        left_q <= {2'b00, i_tx_bits} + {1'b0, i_rx_bytes, 3'h0};
                        rxb_q  <= 3'h0;
                        st_q   <= sfp_pkg::H_SHIFT;
                    end
                sfp_pkg::H_SHIFT:
                    if (tick && !sck_q && left_q == 8'h00)
                        st_q <= sfp_pkg::H_END;
                    else if (tick && !sck_q)
                    begin
                        sck_q  <= 1'b1;
                        left_q <= left_q - 8'h01;
                        if (txl_q != 6'h00)
                            txl_q <= txl_q - 6'h01;
                        else
                        begin
                            rx_q  <= {rx_q[6:0], s_so};
                            rxb_q <= rxb_q + 3'h1;
                            if (rxb_q == 3'h7)
                            begin
                                o_rx_data  <= {rx_q[6:0], s_so};
                                o_rx_valid <= 1'b1;
                            end
                        end
                    end
                    else if (tick)
                    begin
                        sck_q <= 1'b0;
                        si_q  <= tx_q[39];
                        tx_q  <= {tx_q[38:0], 1'b0};
                    end
                sfp_pkg::H_END:
                    if (tick && !cs_n_q)
                        cs_n_q <= 1'b1;
                    else if (tick)
                        st_q <= sfp_pkg::H_IDLE;
                default:
                    st_q <= sfp_pkg::H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bus.sck    = sck_q;
    assign bus.cs_n   = cs_n_q;
    assign bus.si     = si_q;
    assign bus.hold_n = hold_n_q;
    assign o_ready    = st_q == sfp_pkg::H_IDLE;
endmodule : sfp_host

// File: tb/sfp_sva.sv
// Purpose: Wire checks on the serial flash link
// Assumes: One clock domain, synchronous reset
// Notes:   Sits beside the interface that joins both ends
module sfp_sva (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Link wires
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic so_line
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_held; (!cs_n && !hold_n) [*6]; endsequence
    sequence s_idle; cs_n [*6]; endsequence
    property p_rst; $fell(i_sys_rst) |-> !so_oe && cs_n && !sck; endproperty
    a_rst: assert property (p_rst) else $error("link busy after reset");
    property p_pu; $fell(i_sys_rst) |-> cs_n [*8]; endproperty
    a_pu: assert property (p_pu) else $error("select before power-up wait");
    property p_oe; $rose(so_oe) |-> !sck && !cs_n && hold_n; endproperty
    a_oe: assert property (p_oe) else $error("output enabled off a falling edge");
    property p_so; so_oe && $changed(so) |-> !sck; endproperty
    a_so: assert property (p_so) else $error("data changed with clock high");
    property p_cs; s_idle |-> !so_oe; endproperty
    a_cs: assert property (p_cs) else $error("output driven while deselected");
    property p_held; s_held |-> !so_oe; endproperty
    a_held: assert property (p_held) else $error("output driven while held");
    property p_hpin; $changed(hold_n) |-> !sck; endproperty
    a_hpin: assert property (p_hpin) else $error("hold moved with clock high");
    property p_frz; s_held |-> $stable(sck); endproperty
    a_frz: assert property (p_frz) else $error("clock ran while held");
endmodule : sfp_sva

// File: tb/tb.sv
// Purpose: Both link ends joined, driven through the host request port
// Assumes: Short power-up count, operation count twice the default
// Notes:   Expected bytes are queued by the driver
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk      = 1'b0;
    logic        i_sys_rst  = 1'b1;
    logic        i_start    = 1'b0;
    logic        i_hold     = 1'b0;
    logic [39:0] i_tx_data  = 40'h0;
    logic [5:0]  i_tx_bits  = 6'h0;
    logic [3:0]  i_rx_bytes = 4'h0;
    logic        o_ready, o_rx_valid, o_busy, o_wel, o_pwr_down, o_hold;
    logic [7:0]  o_rx_data, o_status, o_op_code;
    logic [15:0] rnd        = 16'hA2C5;
    logic [7:0]  exp_q[$];
    int          failures   = 0;
    int          checked    = 0;
    sfp_if lk ();
    sfp_dev #(.OP_CYCLES(2000)) sfp_dev_i (.i_clk, .i_sys_rst, .i_ce(1'b1), .bus(lk.dev),
        .o_busy, .o_wel, .o_pwr_down, .o_hold, .o_op_start(), .o_op_code, .o_status);
    sfp_host #(.PU_CYCLES(20)) sfp_host_i (.i_clk, .i_sys_rst, .i_ce(1'b1), .bus(lk.host),
        .i_start, .i_tx_data, .i_tx_bits, .i_rx_bytes, .i_hold, .o_ready, .o_rx_data, .o_rx_valid);
    sfp_sva sfp_sva_i (.i_clk, .i_sys_rst, .sck(lk.sck), .cs_n(lk.cs_n), .si(lk.si),
        .hold_n(lk.hold_n), .so(lk.so), .so_oe(lk.so_oe), .so_line(lk.so_line));
    always #4 i_clk = ~i_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_flag(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_flag

    task automatic wrap_up();
        chk_byte(8'(exp_q.size()), 8'h00);
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Bounded wait for the host, and for the device operation if asked
    task automatic wait_idle(input bit op);
        int k;
        k = 0;
        while (o_ready !== 1'b1 || (op && o_busy !== 1'b0))
        begin
            @(negedge i_clk);
            k++;
            if (k > 5000)
            begin
                failures++;
                wrap_up();
            end
        end
    endtask : wait_idle

    task automatic xfer(input logic [39:0] d, input logic [5:0] n, input logic [3:0] r);
        wait_idle(1'b0);
        i_tx_data = d;
        i_tx_bits = n;
        i_rx_bytes = r;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        @(negedge i_clk);
        wait_idle(1'b0);
    endtask : xfer

    always @(negedge i_clk)
        if (o_rx_valid === 1'b1)
            chk_byte(o_rx_data, exp_q.pop_front());

    initial
    begin
        repeat (10) @(negedge i_clk);
        i_sys_rst = 1'b0;
        @(negedge i_clk);
        chk_flag(o_pwr_down, 1'b0);
        chk_flag(o_wel, 1'b0);
        exp_q = '{8'hA7, 8'h5B, 8'h2C, 8'hE1, 8'hA7, 8'h5B};
        fork
            xfer({8'h9F, 32'h0}, 6'h08, 4'h6);
            begin
                repeat (300) @(negedge i_clk);
                i_hold = 1'b1;
                repeat (40) @(negedge i_clk);
                chk_flag(o_hold, 1'b1);
                i_hold = 1'b0;
                repeat (10) @(negedge i_clk);
                chk_flag(o_hold, 1'b0);
            end
        join
        rnd = lfsr(rnd);
        exp_q = '{8'h4D, 8'h4D};
        xfer({8'hAB, rnd, rnd[7:0], 8'h00}, 6'h20, 4'h2);
        xfer({8'h06, 32'h0}, 6'h08, 4'h0);
        chk_flag(o_wel, 1'b1);
        xfer({8'h01, rnd, 16'h0}, 6'h18, 4'h0);
        xfer({8'h20, rnd, 16'h0}, 6'h1F, 4'h0);
        xfer({8'h02, rnd, 16'h0}, 6'h27, 4'h0);
        chk_flag(o_busy, 1'b0);
        chk_flag(o_wel, 1'b1);
        xfer({8'h01, rnd[15:8], 24'h0}, 6'h10, 4'h0);
        chk_flag(o_busy, 1'b1);
        chk_byte(o_status, rnd[15:8]);
        chk_byte(o_op_code, 8'h01);
        exp_q = '{8'hFF, 8'hFF};
        xfer({8'h9F, 32'h0}, 6'h08, 4'h2);
        wait_idle(1'b1);
        chk_flag(o_wel, 1'b0);
        xfer({8'hB9, 32'h0}, 6'h08, 4'h0);
        chk_flag(o_pwr_down, 1'b1);
        xfer({8'h06, 32'h0}, 6'h08, 4'h0);
        chk_flag(o_wel, 1'b0);
        xfer({8'hAB, 32'h0}, 6'h08, 4'h0);
        chk_flag(o_pwr_down, 1'b0);
        wrap_up();
    end
endmodule : tb
